// ### rstseq_pkg.sv
// Constants shared by the bidirectional reset sequencer.
// Assumes a 40 MHz core clock; one clock half-period is half a cycle.
package rstseq_pkg;

    // ------------------------------------------------------------------
    // Timing.
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 25000;
    localparam int HALF_PERIOD_PS = 12500;
    localparam int LATE_SAMPLE_TCL = 8;
    localparam int SHORT_DETECT_TCL = 4;
    localparam int SEQ_TCL = 1024;
    // Least times round up to whole cycles.
    localparam int LATE_SAMPLE_CYC =
        (LATE_SAMPLE_TCL * HALF_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SHORT_DETECT_CYC =
        (SHORT_DETECT_TCL * HALF_PERIOD_PS + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int SEQ_CYC =
        (SEQ_TCL * HALF_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ------------------------------------------------------------------
    // System configuration and sampling masks.
    // ------------------------------------------------------------------
    localparam int BIDIR_EN_BIT = 3;
    localparam logic [15:0] SYSCFG_RESET = 16'h0000;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] MASK_SW_WDT = 16'h1FC0;
    localparam logic [15:0] MASK_SHORT = 16'h1FFF;
    localparam logic [15:0] MASK_ALL = 16'hFFFF;
    localparam int BUS_TYPE_LSB = 6;

    // Reset cause flag positions.
    localparam int FLAG_PON = 4;
    localparam int FLAG_LONG = 3;
    localparam int FLAG_SHORT = 2;
    localparam int FLAG_SW = 1;
    localparam int FLAG_WDT = 0;

    typedef enum logic [2:0] {
        KIND_SW = 3'h0,
        KIND_WDT = 3'h1,
        KIND_SHORT = 3'h2,
        KIND_LONG = 3'h3,
        KIND_ASYNC = 3'h4,
        KIND_PON = 3'h5
    } kind_t;

    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_SEQ = 5'h02,
        ST_LATE = 5'h04,
        ST_WATCH = 5'h08,
        ST_INIT = 5'h10
    } state_t;

endpackage

// ### reset_sequencer.sv
// Bidirectional reset sequencer: runs internal reset sequences, drives
// the reset output and the open-drain pull-down, promotes reset kinds and
// latches the configuration port.
// Assumes all inputs but rst_b are synchronous to clk and requests are pulses.
module reset_sequencer #(
    parameter int SEQ_CYCLES = rstseq_pkg::SEQ_CYC,
    parameter int CNT_W = 12
) (
    input wire logic clk, // Core clock, 40 MHz.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic sw_reset_req, // Software reset request pulse.
    input wire logic wdt_reset_req, // Watchdog reset request pulse.
    input wire logic short_hw_req, // Synchronous hardware reset pulse.
    input wire logic async_hw_req, // Asynchronous hardware reset pulse.
    input wire logic pon_req, // Power-on reset pulse.
    input wire logic filtered_reset_input, // Filtered reset input level.
    input wire logic end_of_init_instr, // End of initialisation pulse.
    input wire logic syscfg_wr, // Write strobe for the enable bit.
    input wire logic [15:0] syscfg_wdata, // Write data, bit 3 used.
    input wire logic return_power_down_pin, // Power-down return pin.
    input wire logic external_access_pin, // External access pin.
    input wire logic [15:0] config_sample_port, // cfg_high_byte, low.
    output logic reset_out_pin_b, // Reset output, active low.
    output logic reset_in_pin_o, // Reset input pin drive value.
    output logic reset_in_pin_oe, // Pull-down enable, high drives.
    output logic core_reset, // Internal reset active.
    output logic [15:0] config_sample_port_config_latch, // Latched port sample.
    output logic [15:0] system_config_reg, // System configuration.
    output logic [1:0] bus_config0_reg, // Bus type field.
    output logic [4:0] reset_flags // Reset cause flags.
);

    // ------------------------------------------------------------------
    // Parameter check.
    // ------------------------------------------------------------------
    if (SEQ_CYCLES < 2 || SEQ_CYCLES >= (1 << CNT_W)) begin : g_bad
        $error("SEQ_CYCLES does not fit the sequence counter");
    end

    // ------------------------------------------------------------------
    // Reset release synchroniser.
    // ------------------------------------------------------------------
    logic rst_meta_r;
    logic rst_sync_b;

    // Release through two flops so no flop sees a ragged deassertion.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_r <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_b <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer state.
    // ------------------------------------------------------------------
    rstseq_pkg::state_t state_r;
    rstseq_pkg::kind_t kind_r;
    rstseq_pkg::kind_t req_kind;
    logic [CNT_W-1:0] cnt_r;
    logic req_any;
    logic bidir_en;
    logic init_done_r;
    logic seq_end;
    logic late_end;
    logic watch_hit;
    logic promote;
    logic config_load;
    logic [15:0] sample_mask;
    logic [15:0] sample_next;
    rstseq_pkg::kind_t load_kind;

    assign bidir_en = system_config_reg[rstseq_pkg::BIDIR_EN_BIT];

    // Request priority: power-on, then asynchronous, then hardware ones.
    always_comb begin
        req_any = 1'b1;
        if (pon_req) begin
            req_kind = rstseq_pkg::KIND_PON;
        end else if (async_hw_req) begin
            req_kind = rstseq_pkg::KIND_ASYNC;
        end else if (short_hw_req) begin
            req_kind = rstseq_pkg::KIND_SHORT;
        end else if (wdt_reset_req) begin
            req_kind = rstseq_pkg::KIND_WDT;
        end else begin
            req_kind = rstseq_pkg::KIND_SW;
            req_any = sw_reset_req;
        end
    end

    assign seq_end = (state_r == rstseq_pkg::ST_SEQ)
        && (cnt_r == CNT_W'(SEQ_CYCLES - 1));
    assign late_end = (state_r == rstseq_pkg::ST_LATE)
        && (cnt_r == CNT_W'(rstseq_pkg::LATE_SAMPLE_CYC - 1));
    // A low held for the full detection time turns into a short reset.
    assign watch_hit = (state_r == rstseq_pkg::ST_WATCH)
        && !filtered_reset_input
        && (cnt_r == CNT_W'(rstseq_pkg::SHORT_DETECT_CYC - 1));
    assign promote = late_end && !filtered_reset_input;

    // Main state machine. A new request restarts the sequence from
    // run, init or watch; requests in the sequence or late sample are ignored.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state_r <= rstseq_pkg::ST_RUN;
            kind_r <= rstseq_pkg::KIND_PON;
            cnt_r <= '0;
        end else begin
            unique case (state_r)
                rstseq_pkg::ST_SEQ: begin
                    cnt_r <= cnt_r + CNT_W'(1);
                    if (seq_end) begin
                        cnt_r <= '0;
                        if (!bidir_en) begin
                            state_r <= rstseq_pkg::ST_INIT;
                        end else if (kind_r == rstseq_pkg::KIND_SHORT) begin
                            state_r <= rstseq_pkg::ST_LATE;
                        end else if (kind_r == rstseq_pkg::KIND_SW
                                || kind_r == rstseq_pkg::KIND_WDT) begin
                            state_r <= rstseq_pkg::ST_WATCH;
                        end else begin
                            state_r <= rstseq_pkg::ST_INIT;
                        end
                    end
                end
                rstseq_pkg::ST_LATE: begin
                    cnt_r <= cnt_r + CNT_W'(1);
                    if (late_end) begin
                        cnt_r <= '0;
                        state_r <= rstseq_pkg::ST_INIT;
                        if (promote) begin
                            kind_r <= rstseq_pkg::KIND_LONG;
                        end
                    end
                end
                rstseq_pkg::ST_WATCH: begin
                    // A high input closes the window: shorter lows are noise.
                    cnt_r <= cnt_r + CNT_W'(1);
                    if (watch_hit) begin
                        cnt_r <= '0;
                        kind_r <= rstseq_pkg::KIND_SHORT;
                        state_r <= rstseq_pkg::ST_SEQ;
                    end else if (filtered_reset_input || req_any) begin
                        cnt_r <= '0;
                        state_r <= req_any ? rstseq_pkg::ST_SEQ
                            : rstseq_pkg::ST_INIT;
                        if (req_any) begin
                            kind_r <= req_kind;
                        end
                    end
                end
                rstseq_pkg::ST_RUN, rstseq_pkg::ST_INIT: begin
                    cnt_r <= '0;
                    if (req_any) begin
                        state_r <= rstseq_pkg::ST_SEQ;
                        kind_r <= req_kind;
                    end else if (state_r == rstseq_pkg::ST_INIT
                            && end_of_init_instr) begin
                        state_r <= rstseq_pkg::ST_RUN;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Reset output and pull-down.
    // ------------------------------------------------------------------
    logic pd_allow;

    // Reset output goes low at any sequence start, high after init end.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            init_done_r <= 1'b0;
        end else if (state_r != rstseq_pkg::ST_SEQ && req_any) begin
            init_done_r <= 1'b0;
        end else if (watch_hit) begin
            init_done_r <= 1'b0;
        end else if ((state_r == rstseq_pkg::ST_INIT
                || state_r == rstseq_pkg::ST_WATCH) && end_of_init_instr) begin
            init_done_r <= 1'b1;
        end
    end

    assign reset_out_pin_b = init_done_r;
    assign core_reset = (state_r == rstseq_pkg::ST_SEQ)
        || (state_r == rstseq_pkg::ST_LATE);

    // Software and watchdog resets pull only with both pins high.
    assign pd_allow = !(kind_r == rstseq_pkg::KIND_SW
        || kind_r == rstseq_pkg::KIND_WDT)
        || (return_power_down_pin && external_access_pin);
    assign reset_in_pin_oe = bidir_en && pd_allow
        && (state_r == rstseq_pkg::ST_SEQ);
    assign reset_in_pin_o = 1'b0;

    // ------------------------------------------------------------------
    // System configuration enable bit.
    // ------------------------------------------------------------------
    // The enable freezes once initialisation has ended.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            system_config_reg <= rstseq_pkg::SYSCFG_RESET;
        end else if (syscfg_wr && !init_done_r && !core_reset) begin
            system_config_reg[rstseq_pkg::BIDIR_EN_BIT] <=
                syscfg_wdata[rstseq_pkg::BIDIR_EN_BIT];
        end else if (config_load) begin
            system_config_reg[15:8] <= sample_next[15:8];
        end
    end

    // ------------------------------------------------------------------
    // Configuration sampling.
    // ------------------------------------------------------------------
    // Sampling happens when the core leaves reset, with the final kind.
    assign config_load = (seq_end && !(bidir_en
        && kind_r == rstseq_pkg::KIND_SHORT)) || late_end;
    assign load_kind = promote ? rstseq_pkg::KIND_LONG : kind_r;

    always_comb begin
        unique case (load_kind)
            rstseq_pkg::KIND_SW, rstseq_pkg::KIND_WDT:
                sample_mask = rstseq_pkg::MASK_SW_WDT;
            rstseq_pkg::KIND_SHORT:
                sample_mask = rstseq_pkg::MASK_SHORT;
            rstseq_pkg::KIND_LONG:
                sample_mask = rstseq_pkg::MASK_ALL;
            default:
                sample_mask = rstseq_pkg::MASK_ALL;
        endcase
        sample_next = (config_sample_port & sample_mask)
            | (config_sample_port_config_latch & ~sample_mask);
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            config_sample_port_config_latch <= rstseq_pkg::CFG_RESET;
            bus_config0_reg <= 2'h0;
        end else if (config_load) begin
            config_sample_port_config_latch <= sample_next;
            bus_config0_reg <= sample_next[rstseq_pkg::BUS_TYPE_LSB +: 2];
        end
    end

    // ------------------------------------------------------------------
    // Reset cause flags.
    // ------------------------------------------------------------------
    logic [4:0] flags_nxt;

    // Flags show the latest kind; promotions overwrite earlier ones.
    always_comb begin
        flags_nxt = 5'h00;
        unique case (load_kind)
            rstseq_pkg::KIND_SW: flags_nxt[rstseq_pkg::FLAG_SW] = 1'b1;
            rstseq_pkg::KIND_WDT: begin
                flags_nxt[rstseq_pkg::FLAG_SW] = 1'b1;
                flags_nxt[rstseq_pkg::FLAG_WDT] = 1'b1;
            end
            rstseq_pkg::KIND_SHORT: flags_nxt[rstseq_pkg::FLAG_SHORT] = 1'b1;
            rstseq_pkg::KIND_LONG: flags_nxt[rstseq_pkg::FLAG_LONG] = 1'b1;
            rstseq_pkg::KIND_ASYNC: flags_nxt[rstseq_pkg::FLAG_LONG] = 1'b1;
            default: flags_nxt[rstseq_pkg::FLAG_PON] = 1'b1;
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            reset_flags <= 5'h10;
        end else if (config_load) begin
            reset_flags <= flags_nxt;
        end
    end

endmodule

// ### rstseq_checker.sv
// Concurrent checks on the reset sequencer's ports.
// Assumes one clock domain and is bound to every sequencer instance.
module rstseq_checker #(
    parameter int SEQ_CYCLES = 8
) (
    input wire logic clk, // Core clock.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic sw_reset_req, // Software request.
    input wire logic wdt_reset_req, // Watchdog request.
    input wire logic short_hw_req, // Short hardware request.
    input wire logic async_hw_req, // Asynchronous hardware request.
    input wire logic pon_req, // Power-on request.
    input wire logic end_of_init_instr, // End of initialisation.
    input wire logic syscfg_wr, // Enable write strobe.
    input wire logic return_power_down_pin, // Power-down return pin.
    input wire logic external_access_pin, // External access pin.
    input wire logic [15:0] config_sample_port, // Sampled port.
    input wire logic reset_out_pin_b, // Reset output.
    input wire logic reset_in_pin_oe, // Pull-down enable.
    input wire logic core_reset, // Internal reset.
    input wire logic [15:0] config_sample_port_config_latch, // Latched sample.
    input wire logic [15:0] system_config_reg, // System configuration.
    input wire logic [4:0] reset_flags // Cause flags.
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------------
    // Helpers and properties.
    // ------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic any_req;
    logic hi_req;
    logic [11:0] oe_run;
    assign any_req = sw_reset_req | wdt_reset_req | hi_req;
    assign hi_req = short_hw_req | async_hw_req | pon_req;
    // Counts the pull-down run so its length can be checked at the end.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) oe_run <= 12'h000;
        else oe_run <= reset_in_pin_oe ? oe_run + 12'h001 : 12'h000;
    end
    property p_take;
        any_req && !core_reset |=> core_reset && !reset_out_pin_b;
    endproperty
    a_take: assert property (p_take) else $error("request not taken");
    property p_hold;
        core_reset |-> !reset_out_pin_b;
    endproperty
    a_hold: assert property (p_hold) else $error("output high in reset");
    property p_end_of_init_instr;
        $rose(reset_out_pin_b) |-> $past(end_of_init_instr);
    endproperty
    a_end_of_init_instr: assert property (p_end_of_init_instr) else $error("early output rise");
    property p_lock;
        reset_out_pin_b && syscfg_wr |=> $stable(system_config_reg[3]);
    endproperty
    a_lock: assert property (p_lock) else $error("enable changed late");
    property p_pull;
        reset_in_pin_oe |-> core_reset;
    endproperty
    a_pull: assert property (p_pull) else $error("pull outside reset");
    property p_sw_on;
        (sw_reset_req || wdt_reset_req) && !core_reset && system_config_reg[3]
            && return_power_down_pin && external_access_pin |=> reset_in_pin_oe;
    endproperty
    a_sw_on: assert property (p_sw_on) else $error("no pull");
    property p_sw_off;
        (sw_reset_req || wdt_reset_req) && !hi_req && !core_reset
            && !return_power_down_pin |=> !reset_in_pin_oe;
    endproperty
    a_sw_off: assert property (p_sw_off) else $error("stray pull");
    property p_len;
        $fell(reset_in_pin_oe) |-> oe_run == SEQ_CYCLES;
    endproperty
    a_len: assert property (p_len) else $error("pull length wrong");
    property p_swmask;
        $fell(core_reset) && reset_flags[1] |->
            ((config_sample_port_config_latch ^ $past(config_sample_port_config_latch))
            & ~rstseq_pkg::MASK_SW_WDT) == 16'h0000;
    endproperty
    a_swmask: assert property (p_swmask) else $error("sw mask");
    property p_short;
        $fell(core_reset) && reset_flags[2] |->
            ((config_sample_port_config_latch ^ $past(config_sample_port))
            & rstseq_pkg::MASK_SHORT) == 16'h0000;
    endproperty
    a_short: assert property (p_short) else $error("short sample");
    property p_long;
        $fell(core_reset) && reset_flags[3] |->
            config_sample_port_config_latch == $past(config_sample_port);
    endproperty
    a_long: assert property (p_long) else $error("long sample");
    c_pull: cover property ($fell(reset_in_pin_oe));
    c_short: cover property ($fell(core_reset) && reset_flags[2]);
    c_long: cover property ($fell(core_reset) && reset_flags[3]);
endmodule

bind reset_sequencer rstseq_checker #(.SEQ_CYCLES(SEQ_CYCLES)) i_chk (
    .clk(clk), .rst_b(rst_b), .sw_reset_req(sw_reset_req),
    .wdt_reset_req(wdt_reset_req), .short_hw_req(short_hw_req),
    .async_hw_req(async_hw_req), .pon_req(pon_req),
    .end_of_init_instr(end_of_init_instr), .syscfg_wr(syscfg_wr),
    .return_power_down_pin(return_power_down_pin),
    .external_access_pin(external_access_pin),
    .config_sample_port(config_sample_port),
    .reset_out_pin_b(reset_out_pin_b), .reset_in_pin_oe(reset_in_pin_oe),
    .core_reset(core_reset), .config_sample_port_config_latch(config_sample_port_config_latch),
    .system_config_reg(system_config_reg), .reset_flags(reset_flags));

// ### rstseq_partner.sv
// External device sharing the pulled-up reset input line.
// Assumes the bench tells it when to hold the line low.
module rstseq_partner (
    input wire logic hold_low, // Far device pulls the line low.
    input wire logic reset_in_pin_o, // Sequencer drive value.
    input wire logic reset_in_pin_oe, // Sequencer pull-down enable.
    output logic filtered_reset_input // Resolved line level.
);
    timeunit 1ns;
    timeprecision 100ps;
    // Open drain with pull-up: the far side lets go at once when told. 
    assign filtered_reset_input = !(hold_low ||
        (reset_in_pin_oe && !reset_in_pin_o));
endmodule

// ### bidirectional_reset_sequencer_tb.sv
// Self-checking bench for the reset sequencer with a far-side model.
// Assumes the checker is bound through its own file.
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module bidirectional_reset_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_b, end_of_init_instr, syscfg_wr, hold_low;
    logic sw_reset_req, wdt_reset_req, short_hw_req, async_hw_req, pon_req;
    logic return_power_down_pin, external_access_pin, filtered_reset_input;
    logic [15:0] syscfg_wdata, config_sample_port, config_sample_port_config_latch;
    logic [15:0] system_config_reg, exp_latch;
    logic reset_out_pin_b, reset_in_pin_o, reset_in_pin_oe, core_reset;
    logic prev_core;
    logic [1:0] bus_config0_reg;
    logic [4:0] reset_flags;
    logic [20:0] q[$];
    logic [20:0] n;
    logic [31:0] rnd;
    int checked, err_total, k;
    reset_sequencer #(.SEQ_CYCLES(8)) i_dut (.clk(clk), .rst_b(rst_b),
        .sw_reset_req(sw_reset_req), .wdt_reset_req(wdt_reset_req),
        .short_hw_req(short_hw_req), .async_hw_req(async_hw_req),
        .pon_req(pon_req), .filtered_reset_input(filtered_reset_input),
        .end_of_init_instr(end_of_init_instr), .syscfg_wr(syscfg_wr),
        .syscfg_wdata(syscfg_wdata),
        .return_power_down_pin(return_power_down_pin),
        .external_access_pin(external_access_pin),
        .config_sample_port(config_sample_port),
        .reset_out_pin_b(reset_out_pin_b), .reset_in_pin_o(reset_in_pin_o),
        .reset_in_pin_oe(reset_in_pin_oe), .core_reset(core_reset),
        .config_sample_port_config_latch(config_sample_port_config_latch),
        .system_config_reg(system_config_reg),
        .bus_config0_reg(bus_config0_reg), .reset_flags(reset_flags));
    rstseq_partner i_far (.hold_low(hold_low),
        .reset_in_pin_o(reset_in_pin_o), .reset_in_pin_oe(reset_in_pin_oe),
        .filtered_reset_input(filtered_reset_input));
    // ------------------------------------------------------------------
    // Clock, helpers and tasks.
    // ------------------------------------------------------------------
    always #12.5 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task tick(input int c);
        repeat (c) @(negedge clk);
    endtask
    task conclude;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Queues the flags and latch expected when a coming sequence ends.
    task note(input logic [4:0] f, input logic [15:0] m);
        exp_latch = (exp_latch & ~m) | (config_sample_port & m);
        q.push_back({f, exp_latch});
    endtask
    // Kind 0 software, 1 watchdog, 2 short, 3 asynchronous, 4 power-on.
    task pulse(input int kind);
        {pon_req, async_hw_req, short_hw_req, wdt_reset_req,
            sw_reset_req} = 5'h01 << kind;
        tick(1);
        {pon_req, async_hw_req, short_hw_req, wdt_reset_req,
            sw_reset_req} = 5'h00;
    endtask
    // A hang here is counted and ends the run.
    task wait_core(input logic lvl);
        int i;
        for (i = 0; i < 100 && core_reset !== lvl; i++) tick(1);
        if (core_reset !== lvl) begin
            err_total++;
            conclude();
        end
    endtask
    task new_port;
        rnd = lfsr(rnd);
        config_sample_port = rnd[15:0];
    endtask
    // ------------------------------------------------------------------
    // Monitor: each sequence end takes the oldest note.
    // ------------------------------------------------------------------
    always @(negedge clk) begin
        if (prev_core && !core_reset) begin
            if (q.size() == 0) `CHK("extra end", 1'b0, 1'b1)
            else begin
                n = q.pop_front();
                `CHK("flags", n[20:16], reset_flags)
                `CHK("latch", n[15:0], config_sample_port_config_latch)
                `CHK("bus", n[7:6], bus_config0_reg)
                `CHK("syscfg", n[15:8], system_config_reg[15:8])
            end
        end
        prev_core = core_reset;
    end
    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        {clk, rst_b, end_of_init_instr, syscfg_wr, hold_low} = 5'h00;
        {pon_req, async_hw_req, short_hw_req, wdt_reset_req} = 4'h0;
        sw_reset_req = 1'b0;
        {return_power_down_pin, external_access_pin, prev_core} = 3'h6;
        {syscfg_wdata, config_sample_port, exp_latch} = 48'h0;
        rnd = 32'h221E;
        tick(4);
        rst_b = 1'b1;
        tick(3);
        `CHK("flags rst", 5'h10, reset_flags)
        `CHK("out rst", 1'b0, reset_out_pin_b)
        rnd = lfsr(rnd);
        syscfg_wdata = rnd[15:0] | 16'h0008;
        syscfg_wr = 1'b1;
        tick(1);
        syscfg_wr = 1'b0;
        `CHK("enable", 1'b1, system_config_reg[3])
        // Software and watchdog, with and without the power-down pin.
        for (k = 0; k < 4; k++) begin
            new_port();
            return_power_down_pin = !k[1];
            note({4'h1, k[0]}, rstseq_pkg::MASK_SW_WDT);
            pulse(k % 2);
            `CHK("pull", !k[1], reset_in_pin_oe)
            `CHK("drive", 1'b0, reset_in_pin_o)
            wait_core(1'b0);
            `CHK("release", 1'b0, reset_in_pin_oe)
            hold_low = 1'b1;
            tick(1);
            hold_low = 1'b0;
            tick(4);
        end
        // A sustained low after a software reset turns it into a short one.
        new_port();
        hold_low = 1'b1;
        note(5'h02, rstseq_pkg::MASK_SW_WDT);
        note(5'h04, rstseq_pkg::MASK_SHORT);
        pulse(0);
        wait_core(1'b0);
        wait_core(1'b1);
        hold_low = 1'b0;
        wait_core(1'b0);
        // Short hardware reset, then one held low past the late sample.
        for (k = 0; k < 2; k++) begin
            new_port();
            hold_low = k[0];
            note(k[0] ? 5'h08 : 5'h04,
                k[0] ? rstseq_pkg::MASK_ALL : rstseq_pkg::MASK_SHORT);
            pulse(2);
            wait_core(1'b0);
            hold_low = 1'b0;
            tick(4);
        end
        // Asynchronous with a refused request inside, then power-on.
        new_port();
        note(5'h08, rstseq_pkg::MASK_ALL);
        pulse(3);
        tick(1);
        pulse(0);
        wait_core(1'b0);
        new_port();
        note(5'h10, rstseq_pkg::MASK_ALL);
        pulse(4);
        wait_core(1'b0);
        end_of_init_instr = 1'b1;
        tick(1);
        end_of_init_instr = 1'b0;
        `CHK("out end_of_init_instr", 1'b1, reset_out_pin_b)
        syscfg_wdata = 16'h0000;
        syscfg_wr = 1'b1;
        tick(1);
        syscfg_wr = 1'b0;
        tick(1);
        `CHK("locked", 1'b1, system_config_reg[3])
        note(5'h02, rstseq_pkg::MASK_SW_WDT);
        pulse(0);
        `CHK("out sw", 1'b0, reset_out_pin_b)
        wait_core(1'b0);
        tick(4);
        `CHK("queue", 0, q.size())
        conclude();
    end
endmodule
